// file: cfg_menu_defs.vh
`ifndef CFG_MENU_DEFS_VH
`define CFG_MENU_DEFS_VH

// clock rate and times, each in its own unit
`define CLK_HZ 64'd10000000
`define IDLE_MIN 64'd15
`define CAL_HOURS 64'd2
`define CAL_HOLD_SEC 64'd5
`define STEP_SEC 64'd5
`define TEST_HOLD_SEC 64'd2
`define LOGO_SEC 64'd3
`define SEC_PER_MIN 64'd60
`define SEC_PER_HOUR 64'd3600

// register byte offsets
`define REG_CTRL 8'h00
`define REG_DISPLAY 8'h04
`define REG_BUS 8'h08
`define REG_NET 8'h0C
`define REG_CHTYPE 8'h10
`define REG_THR01 8'h14
`define REG_THR23 8'h18
`define REG_STATUS 8'h1C

// field positions
`define CTRL_BAND 0
`define DISP_UPPER 7:0
`define DISP_LOWER 15:8
`define BUS_ADDR 7:0
`define BUS_BAUD 9:8
`define BUS_RTO 23:16
`define NET_CHAN 7:0
`define NET_PRIMARY 8
`define NET_FREL 9
`define NET_FS 13:10
`define NET_FTFS 14
`define NET_AUTO 19:16
`define NET_INCR 23:20
`define THR_LO 15:0
`define THR_HI 31:16
`define ST_MODE 4:0
`define ST_STEP 15:5
`define ST_RELAY 19:16
`define ST_F15 20
`define ST_FTERM 21
`define ST_FSIDX 23:22

// value ranges and reset values
`define CON_DEF 8'h80
`define CON_MIN 8'h00
`define CON_MAX 8'hFF
`define ADDR_DEF 8'h01
`define ADDR_MIN 8'h01
`define ADDR_MAX 8'hF7
`define BAUD_4800 8'h00
`define BAUD_9600 8'h01
`define BAUD_19200 8'h02
`define RTO_MIN 8'h06
`define RTO_MAX 8'hFF
`define RTO_DEF 8'h0A
`define NET_MIN 8'h01
`define NET_MAX_900 8'h34
`define NET_MAX_24 8'h4E
`define NET_DEF 8'h05
`define CHTYPE_DEF 32'h0FFFFFFF
`define THR1_DEF 16'h000A
`define THR2_DEF 16'h000F
`define THR3_DEF 16'h0014
`define THR4_DEF 16'h0019
`define ALL4 4'hF
`define NONE4 4'h0
`define TEST_FIRST 4'h1
`define FS_LAST 2'h3
`define FS_THIRD 2'h2

`endif

// file: tick_timer.v
`timescale 1ns/10ps
`include "cfg_menu_defs.vh"

// counts cycles while run is high; pulses done every LIMIT cycles
module tick_timer #(
	parameter W = 40,
	parameter [63:0] LIMIT = 64'd1
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// control
	input wire run,
	output reg done
);
	localparam [W-1:0] LAST = LIMIT[W-1:0] - {{(W-1){1'b0}}, 1'b1};
	reg [W-1:0] count;

	// dropping run restarts the interval from zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= {W{1'b0}};
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!run) begin
				count <= {W{1'b0}};
			end else if (count == LAST) begin
				count <= {W{1'b0}};
				done <= 1'b1;
			end else begin
				count <= count + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // tick_timer

// file: config_menu_mode_controller.v
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "cfg_menu_defs.vh"

module config_menu_mode_controller #(
	parameter [63:0] IDLE_CYC = `IDLE_MIN * `SEC_PER_MIN * `CLK_HZ,
	parameter [63:0] CAL_CYC = `CAL_HOURS * `SEC_PER_HOUR * `CLK_HZ,
	parameter [63:0] CAL_HOLD_CYC = `CAL_HOLD_SEC * `CLK_HZ,
	parameter [63:0] STEP_CYC = `STEP_SEC * `CLK_HZ,
	parameter [63:0] TEST_HOLD_CYC = `TEST_HOLD_SEC * `CLK_HZ,
	parameter [63:0] LOGO_CYC = `LOGO_SEC * `CLK_HZ
) (
	// apb slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// front panel keys, high while pressed
	input wire next_key,
	input wire increment_key,
	input wire decrement_key,
	input wire exit_key,
	input wire clear_exit_key,
	// alarm and network status
	input wire [3:0] alarm_req,
	input wire fault_any,
	input wire primary_seen,
	// relay and indicator outputs
	output reg [3:0] relay,
	output reg fault_term,
	output reg fault_15,
	output reg led_green,
	output reg led_blue,
	output reg cal_marker,
	output reg menu_active,
	output reg test_active,
	output reg save_pulse
);
	// operating modes, one-hot
	localparam [4:0] M_LOGO = 5'h01;
	localparam [4:0] M_NORM = 5'h02;
	localparam [4:0] M_MENU = 5'h04;
	localparam [4:0] M_CAL = 5'h08;
	localparam [4:0] M_TEST = 5'h10;
	// menu steps, one-hot
	localparam [10:0] S_CONU = 11'h001;
	localparam [10:0] S_CONL = 11'h002;
	localparam [10:0] S_FACT = 11'h004;
	localparam [10:0] S_FREL = 11'h008;
	localparam [10:0] S_FS = 11'h010;
	localparam [10:0] S_FTFS = 11'h020;
	localparam [10:0] S_ADDR = 11'h040;
	localparam [10:0] S_BAUD = 11'h080;
	localparam [10:0] S_RTO = 11'h100;
	localparam [10:0] S_CHAN = 11'h200;
	localparam [10:0] S_ROLE = 11'h400;

	////////////////////////////////////////////////////////////////////////
	// step a value by one within a range
	function [7:0] bump;
		input [7:0] v;
		input up;
		input dn;
		input [7:0] lo;
		input [7:0] hi;
		begin
			if (up && v < hi)
				bump = v + 8'h01;
			else if (dn && v > lo)
				bump = v - 8'h01;
			else
				bump = v;
		end
	endfunction

	// force a written value into its range
	function [7:0] clamp;
		input [7:0] v;
		input [7:0] lo;
		input [7:0] hi;
		begin
			if (v < lo)
				clamp = lo;
			else if (v > hi)
				clamp = hi;
			else
				clamp = v;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	reg [4:0] mode;
	reg [10:0] step;
	reg [1:0] fs_idx;
	reg [3:0] test_sel;
	reg test_released;
	reg [4:0] key_prev;
	reg band_24g;
	reg [7:0] con_upper;
	reg [7:0] con_lower;
	reg [7:0] station;
	reg [7:0] baud;
	reg [7:0] radio_to;
	reg [7:0] net_chan;
	reg primary;
	reg frelay;
	reg [3:0] failsafe;
	reg ftfs;
	reg [3:0] auto_reset;
	reg [3:0] increasing;
	reg [31:0] chtype;
	reg [15:0] thr1;
	reg [15:0] thr2;
	reg [15:0] thr3;
	reg [15:0] thr4;
	reg [31:0] rd_mux;
	reg rd_ok;
	reg [3:0] next_relay;

	// key press edges
	wire [4:0] keys = {clear_exit_key, exit_key, decrement_key,
		increment_key, next_key};
	wire [4:0] press = keys & ~key_prev;
	wire next_press = press[0];
	wire inc_press = press[1];
	wire dec_press = press[2];
	wire exit_press = press[3];
	wire clear_press = press[4];
	wire in_menu = (mode == M_MENU);
	wire [7:0] net_max = band_24g ? `NET_MAX_24 : `NET_MAX_900;
	wire wr_en = psel && penable && pwrite && pready;
	wire idle_done;
	wire cal_done;
	wire cal_hold_done;
	wire test_hold_done;
	wire step_done;
	wire logo_done;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			key_prev <= 5'h00;
		else
			key_prev <= keys;
	end

	////////////////////////////////////////////////////////////////////////
	// interval timers
	tick_timer #(.LIMIT(IDLE_CYC)) idle_tmr (
		.pclk(pclk), .presetn(presetn),
		.run(in_menu && (press == 5'h00)),
		.done(idle_done));
	tick_timer #(.LIMIT(CAL_CYC)) cal_tmr (
		.pclk(pclk), .presetn(presetn),
		.run(mode == M_CAL), .done(cal_done));
	tick_timer #(.LIMIT(CAL_HOLD_CYC)) cal_hold_tmr (
		.pclk(pclk), .presetn(presetn),
		.run((mode == M_NORM) && next_key),
		.done(cal_hold_done));
	tick_timer #(.LIMIT(TEST_HOLD_CYC)) test_hold_tmr (
		.pclk(pclk), .presetn(presetn),
		.run((mode == M_NORM) && clear_exit_key),
		.done(test_hold_done));
	tick_timer #(.LIMIT(STEP_CYC)) step_tmr (
		.pclk(pclk), .presetn(presetn),
		.run(mode == M_TEST), .done(step_done));
	tick_timer #(.LIMIT(LOGO_CYC)) logo_tmr (
		.pclk(pclk), .presetn(presetn),
		.run(mode == M_LOGO), .done(logo_done));

	////////////////////////////////////////////////////////////////////////
	// mode and menu step sequencing
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= M_LOGO;
			step <= S_CONU;
			fs_idx <= 2'h0;
			test_sel <= `NONE4;
			test_released <= 1'b0;
			save_pulse <= 1'b0;
		end else begin
			save_pulse <= 1'b0;
			case (mode)
			M_LOGO: begin
				if (next_press) begin
					mode <= M_MENU;
					step <= S_CONU;
				end else if (logo_done) begin
					mode <= M_NORM;
				end
			end
			M_MENU: begin
				if (exit_press || idle_done) begin
					mode <= M_NORM;
					save_pulse <= 1'b1;
				end else if (next_press) begin
					case (step)
					S_CONU: step <= S_CONL;
					S_CONL: step <= S_FACT;
					S_FACT: step <= S_FREL;
					S_FREL: begin
						step <= S_FS;
						fs_idx <= 2'h0;
					end
					S_FS: begin
						// relay 4 step hidden when it is the fault relay
						if (fs_idx == `FS_LAST ||
							(fs_idx == `FS_THIRD && frelay))
							step <= S_FTFS;
						else
							fs_idx <= fs_idx + 2'h1;
					end
					S_FTFS: step <= S_ADDR;
					S_ADDR: step <= S_BAUD;
					S_BAUD: step <= S_RTO;
					S_RTO: step <= S_CHAN;
					S_CHAN: step <= S_ROLE;
					S_ROLE: begin
						mode <= M_NORM;
						save_pulse <= 1'b1;
					end
					default: step <= S_CONU;
					endcase
				end
			end
			M_NORM: begin
				if (cal_hold_done) begin
					mode <= M_CAL;
				end else if (test_hold_done) begin
					mode <= M_TEST;
					test_sel <= `TEST_FIRST;
					test_released <= 1'b0;
				end
			end
			M_CAL: begin
				if (clear_press || cal_done)
					mode <= M_NORM;
			end
			M_TEST: begin
				if (!clear_exit_key)
					test_released <= 1'b1;
				if (test_released && clear_press) begin
					mode <= M_NORM;
					test_sel <= `NONE4;
				end else if (step_done) begin
					test_sel <= {test_sel[2:0], test_sel[3]};
				end
			end
			default: mode <= M_NORM;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stored settings: bus writes, else key edits in the menu
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			band_24g <= 1'b0;
			con_upper <= `CON_DEF;
			con_lower <= `CON_DEF;
			station <= `ADDR_DEF;
			baud <= `BAUD_9600;
			radio_to <= `RTO_DEF;
			net_chan <= `NET_DEF;
			primary <= 1'b0;
			frelay <= 1'b0;
			failsafe <= `NONE4;
			ftfs <= 1'b0;
			auto_reset <= `ALL4;
			increasing <= `ALL4;
			chtype <= `CHTYPE_DEF;
			thr1 <= `THR1_DEF;
			thr2 <= `THR2_DEF;
			thr3 <= `THR3_DEF;
			thr4 <= `THR4_DEF;
		end else if (wr_en) begin
			case (paddr)
			`REG_CTRL: band_24g <= pwdata[`CTRL_BAND];
			`REG_DISPLAY: begin
				con_upper <= pwdata[`DISP_UPPER];
				con_lower <= pwdata[`DISP_LOWER];
			end
			`REG_BUS: begin
				station <= clamp(pwdata[`BUS_ADDR], `ADDR_MIN,
					`ADDR_MAX);
				baud <= clamp({6'h00, pwdata[`BUS_BAUD]}, `BAUD_4800,
					`BAUD_19200);
				radio_to <= clamp(pwdata[`BUS_RTO], `RTO_MIN,
					`RTO_MAX);
			end
			`REG_NET: begin
				net_chan <= clamp(pwdata[`NET_CHAN], `NET_MIN,
					net_max);
				primary <= pwdata[`NET_PRIMARY];
				frelay <= pwdata[`NET_FREL];
				failsafe <= pwdata[`NET_FS];
				ftfs <= pwdata[`NET_FTFS];
				auto_reset <= pwdata[`NET_AUTO];
				increasing <= pwdata[`NET_INCR];
			end
			`REG_CHTYPE: chtype <= pwdata;
			`REG_THR01: begin
				thr1 <= pwdata[`THR_LO];
				thr2 <= pwdata[`THR_HI];
			end
			`REG_THR23: begin
				thr3 <= pwdata[`THR_LO];
				thr4 <= pwdata[`THR_HI];
			end
			default: band_24g <= band_24g;
			endcase
		end else if (in_menu && (inc_press || dec_press)) begin
			case (step)
			S_CONU: con_upper <= bump(con_upper, inc_press, dec_press,
				`CON_MIN, `CON_MAX);
			S_CONL: con_lower <= bump(con_lower, inc_press, dec_press,
				`CON_MIN, `CON_MAX);
			S_FACT: begin
				if (inc_press) begin
					chtype <= `CHTYPE_DEF;
					thr1 <= `THR1_DEF;
					thr2 <= `THR2_DEF;
					thr3 <= `THR3_DEF;
					thr4 <= `THR4_DEF;
					auto_reset <= `ALL4;
					increasing <= `ALL4;
					baud <= `BAUD_9600;
					radio_to <= `RTO_DEF;
					net_chan <= `NET_DEF;
					primary <= 1'b0;
				end
			end
			S_FREL: frelay <= inc_press;
			S_FS: failsafe[fs_idx] <= inc_press;
			S_FTFS: ftfs <= inc_press;
			S_ADDR: station <= bump(station, inc_press, dec_press,
				`ADDR_MIN, `ADDR_MAX);
			S_BAUD: baud <= bump(baud, inc_press, dec_press,
				`BAUD_4800, `BAUD_19200);
			S_RTO: radio_to <= bump(radio_to, inc_press, dec_press,
				`RTO_MIN, `RTO_MAX);
			S_CHAN: net_chan <= bump(net_chan, inc_press, dec_press,
				`NET_MIN, net_max);
			S_ROLE: primary <= inc_press;
			default: primary <= primary;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// relay drive: failsafe inverts the resting state
	always @* begin
		next_relay = alarm_req ^ failsafe;
		if (frelay)
			next_relay[3] = fault_any ^ failsafe[3];
		if (mode == M_CAL)
			next_relay = `NONE4;
		else if (mode == M_TEST)
			next_relay = test_sel;
	end

	// registered panel outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay <= `NONE4;
			fault_term <= 1'b0;
			fault_15 <= 1'b0;
			led_green <= 1'b0;
			led_blue <= 1'b0;
			cal_marker <= 1'b0;
			menu_active <= 1'b0;
			test_active <= 1'b0;
		end else begin
			relay <= next_relay;
			fault_term <= fault_any ^ ftfs;
			fault_15 <= !primary && !primary_seen;
			led_green <= primary;
			led_blue <= !primary;
			cal_marker <= (mode == M_CAL);
			menu_active <= in_menu;
			test_active <= (mode == M_TEST);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux
	always @* begin
		rd_mux = 32'h00000000;
		rd_ok = 1'b1;
		case (paddr)
		`REG_CTRL: rd_mux[`CTRL_BAND] = band_24g;
		`REG_DISPLAY: begin
			rd_mux[`DISP_UPPER] = con_upper;
			rd_mux[`DISP_LOWER] = con_lower;
		end
		`REG_BUS: begin
			rd_mux[`BUS_ADDR] = station;
			rd_mux[`BUS_BAUD] = baud[1:0];
			rd_mux[`BUS_RTO] = radio_to;
		end
		`REG_NET: begin
			rd_mux[`NET_CHAN] = net_chan;
			rd_mux[`NET_PRIMARY] = primary;
			rd_mux[`NET_FREL] = frelay;
			rd_mux[`NET_FS] = failsafe;
			rd_mux[`NET_FTFS] = ftfs;
			rd_mux[`NET_AUTO] = auto_reset;
			rd_mux[`NET_INCR] = increasing;
		end
		`REG_CHTYPE: rd_mux = chtype;
		`REG_THR01: rd_mux = {thr2, thr1};
		`REG_THR23: rd_mux = {thr4, thr3};
		`REG_STATUS: begin
			rd_mux[`ST_MODE] = mode;
			rd_mux[`ST_STEP] = step;
			rd_mux[`ST_RELAY] = relay;
			rd_mux[`ST_F15] = fault_15;
			rd_mux[`ST_FTERM] = fault_term;
			rd_mux[`ST_FSIDX] = fs_idx;
		end
		default: rd_ok = 1'b0;
		endcase
	end

	// apb answer: data and error captured in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (psel && !penable) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
				pslverr <= !rd_ok;
			end
		end
	end
endmodule // config_menu_mode_controller

// file: cfg_panel_monitor.sv
`timescale 1ns/10ps
// watches the panel controller from its ports
module cfg_panel_monitor #(
	parameter [63:0] CAL_CYC = 64'd40
) (
	// clock, reset and bus
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	// status inputs and outputs
	input wire primary_seen,
	input wire [3:0] relay,
	input wire fault_15,
	input wire led_green,
	input wire led_blue,
	input wire cal_marker,
	input wire menu_active,
	input wire test_active,
	input wire save_pulse
);
	logic [63:0] cal_cnt;
	////////////////////////////////////////////////////////////////////
	// cycles spent in calibration so far
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cal_cnt <= 64'h0;
		else
			cal_cnt <= cal_marker ? cal_cnt + 64'h1 : 64'h0;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// zero wait states, both indicators, relays and mode exits
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("access without ready");
	a_led_role: assert property (led_green |-> !led_blue)
		else $error("both indicator colours on");
	a_fault_code: assert property (
		fault_15 == (led_blue && !$past(primary_seen)))
		else $error("fault 15 wrong for role and network");
	a_cal_quiet: assert property (cal_marker |-> relay == 4'h0)
		else $error("relay energised in calibration");
	a_cal_bound: assert property (cal_cnt <= CAL_CYC + 64'd2)
		else $error("calibration outlasts its timeout");
	// save pulse comes with the mode change, the menu flag one edge later
	a_menu_save: assert property (
		$fell(menu_active) |-> $past(save_pulse) && !save_pulse)
		else $error("menu left without one save pulse");
	a_save_cause: assert property (
		save_pulse |-> menu_active ##1 !menu_active)
		else $error("save pulse without leaving menu");
	a_test_start: assert property (
		$rose(test_active) |-> relay == 4'h1)
		else $error("relay test does not start at relay 1");
	a_test_step: assert property (
		test_active && $past(test_active) && relay != $past(relay)
		|-> {relay[0], relay[3:1]} == $past(relay))
		else $error("relay test does not step in order");
endmodule // cfg_panel_monitor

bind config_menu_mode_controller cfg_panel_monitor #(.CAL_CYC(CAL_CYC))
	cfg_panel_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .primary_seen(primary_seen),
	.relay(relay), .fault_15(fault_15), .led_green(led_green),
	.led_blue(led_blue), .cal_marker(cal_marker),
	.menu_active(menu_active), .test_active(test_active),
	.save_pulse(save_pulse));

// file: operator_panel.sv
`timescale 1ns/10ps
// operator at the keys: bit 0 next, 1 up, 2 down, 3 exit, 4 clear
module operator_panel (
	// clock
	input wire pclk,
	// keys, high while pressed
	output logic [4:0] key
);
	initial key = 5'h00;
	////////////////////////////////////////////////////////////////////
	// key k down for n cycles, then up with a low gap after it
	task automatic hold(input int k, input int n);
		key[k] <= 1'b1;
		repeat (n) @(posedge pclk);
		key[k] <= 1'b0;
		@(posedge pclk);
	endtask
	// a short press
	task automatic press(input int k);
		hold(k, 2);
	endtask
endmodule // operator_panel

// file: test_config_menu_mode_controller.sv
`timescale 1ns/10ps
// self-checking bench for the panel mode controller
module test_config_menu_mode_controller;
	localparam [63:0] IDLE = 64'd60;
	localparam [63:0] CAL = 64'd40;
	localparam [63:0] HOLD = 64'd8;
	localparam int NX = 0;
	localparam int UP = 1;
	localparam int DN = 2;
	localparam int EX = 3;
	localparam int CL = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] alarm_req = 4'h0;
	logic fault_any = 1'b0;
	logic primary_seen = 1'b0;
	wire [31:0] prdata;
	wire pready, pslverr, fault_term, fault_15, led_green, led_blue;
	wire cal_marker, menu_active, test_active, save_pulse;
	wire [3:0] relay;
	wire [4:0] key;
	logic [32:0] eq[$], mq[$], e, m;
	logic [31:0] rv [6] = '{32'h8080, 32'hA0101, 32'hFF0005,
		32'hFFFFFFF, 32'hF000A, 32'h190014};
	logic [1:0] bx [5] = '{2'h2, 2'h2, 2'h1, 2'h0, 2'h0};
	logic [7:0] ch;
	logic [2:0] a;
	int errors = 0;
	int checks = 0;
	int n;
	////////////////////////////////////////////////////////////////////
	// clock and instances
	always #50 pclk = ~pclk;
	operator_panel operator_panel_i (.pclk(pclk), .key(key));
	config_menu_mode_controller #(.IDLE_CYC(IDLE), .CAL_CYC(CAL),
		.CAL_HOLD_CYC(HOLD), .STEP_CYC(64'd6), .TEST_HOLD_CYC(64'd5),
		.LOGO_CYC(64'd10)) config_menu_mode_controller_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .next_key(key[0]),
		.increment_key(key[1]), .decrement_key(key[2]),
		.exit_key(key[3]), .clear_exit_key(key[4]),
		.alarm_req(alarm_req), .fault_any(fault_any),
		.primary_seen(primary_seen), .relay(relay),
		.fault_term(fault_term), .fault_15(fault_15),
		.led_green(led_green), .led_blue(led_blue),
		.cal_marker(cal_marker), .menu_active(menu_active),
		.test_active(test_active), .save_pulse(save_pulse));
	////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic results;
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one counted comparison
	task automatic ck(input logic ok, input string s);
		checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("mismatch %0t %s", $time, s);
		end
	endtask
	// one bus transfer, held until ready is seen at an edge
	task automatic apb(input logic [7:0] ad, input logic w,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 8);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (k >= 8) begin
			ck(1'b0, "no ready");
			results();
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		apb(ad, 1'b1, d);
	endtask
	// a read whose expected value and error flag go in the queue
	task automatic rd(input logic [7:0] ad, input logic [31:0] x, mk);
		eq.push_back({ad > 8'h1C, x});
		mq.push_back({1'b1, mk});
		apb(ad, 1'b0, 32'h0);
	endtask
	task automatic md(input logic [4:0] x);
		rd(8'h1C, {27'h0, x}, 32'h1F);
	endtask
	task automatic pr(input int k);
		operator_panel_i.press(k);
	endtask
	task automatic rst;
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	// takes the oldest expected read off the queue at each read
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && eq.size() > 0) begin
			e = eq.pop_front();
			m = mq.pop_front();
			ck((({pslverr, prdata} ^ e) & m) === 33'h0, "read data");
		end
	end
	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		n = $urandom(32'h81299606);
		rst();
		md(5'h01);
		pr(NX);
		rd(8'h1C, 32'h24, 32'hFFFF);
		for (int i = 0; i < 6; i++)
			rd(8'h04 + 8'(4 * i), rv[i], 32'hFFFFFFFF);
		rd(8'h20, 32'h0, 32'hFFFFFFFF);
		wr(8'h1C, 32'hFFFFFFFF);
		md(5'h04);
		for (int i = 0; i < 4; i++)
			pr(i < 3 ? UP : DN);
		pr(NX);
		pr(DN);
		pr(DN);
		rd(8'h04, 32'h7E82, 32'hFFFF);
		pr(NX);
		wr(8'h08, 32'hFF0005);
		wr(8'h0C, 32'h109);
		wr(8'h10, 32'h0);
		wr(8'h14, 32'h0);
		wr(8'h18, 32'h0);
		pr(UP);
		for (int i = 2; i < 6; i++)
			rd(8'h04 + 8'(4 * i), rv[i], 32'hFFFFFFFF);
		rd(8'h08, 32'hA0100, 32'hFF0300);
		pr(NX);
		pr(UP);
		pr(NX);
		pr(UP);
		pr(NX);
		pr(NX);
		pr(NX);
		rd(8'h1C, 32'h400, 32'hFFE0);
		pr(UP);
		rd(8'h0C, 32'h4600, 32'h7E00);
		pr(NX);
		wr(8'h08, 32'hFF01F7);
		pr(UP);
		pr(UP);
		pr(DN);
		rd(8'h08, 32'hF6, 32'hFF);
		pr(NX);
		for (int i = 0; i < 5; i++) begin
			pr(i < 2 ? UP : DN);
			rd(8'h08, {22'h0, bx[i], 8'h0}, 32'h300);
		end
		pr(NX);
		pr(UP);
		rd(8'h08, 32'hFF0000, 32'hFF0000);
		wr(8'h08, 32'h600F6);
		pr(DN);
		rd(8'h08, 32'h60000, 32'hFF0000);
		pr(NX);
		wr(8'h0C, 32'hFF4634);
		pr(UP);
		rd(8'h0C, 32'h34, 32'hFF);
		wr(8'h00, 32'h1);
		ch = 8'(1 + $urandom % 78);
		wr(8'h0C, {16'hFF, 8'h46, ch});
		pr(UP);
		rd(8'h0C, {24'h0, ch == 8'h4E ? ch : ch + 8'h1}, 32'hFF);
		pr(NX);
		pr(UP);
		rd(8'h1C, 32'h0, 32'h100000);
		ck(led_green === 1'b1 && led_blue === 1'b0, "green");
		pr(DN);
		rd(8'h1C, 32'h100000, 32'h100000);
		ck(led_blue === 1'b1 && led_green === 1'b0, "blue");
		primary_seen <= 1'b1;
		pr(NX);
		md(5'h02);
		a = 3'($urandom);
		alarm_req <= {1'b0, a};
		fault_any <= 1'b1;
		// let the registered relay and fault outputs follow the inputs
		repeat (2) @(posedge pclk);
		rd(8'h1C, 32'h2 | {12'h0, 1'b1, a[2:1], ~a[0], 16'h0},
			32'h3F001F);
		ck(fault_term === 1'b0, "fault terminal");
		operator_panel_i.hold(NX, 4);
		md(5'h02);
		operator_panel_i.hold(NX, 11);
		rd(8'h1C, 32'h8, 32'hF001F);
		ck(cal_marker === 1'b1, "cal marker");
		pr(CL);
		md(5'h02);
		operator_panel_i.hold(NX, 11);
		repeat (CAL + 5) @(posedge pclk);
		md(5'h02);
		fork
			operator_panel_i.hold(CL, 7);
		join_none
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (test_active !== 1'b1 && n < 20);
		ck(relay === 4'h1, "first test relay");
		do begin
			@(posedge pclk);
			n++;
		end while (relay === 4'h1 && n < 40);
		ck(relay === 4'h2, "second test relay");
		repeat (8) @(posedge pclk);
		pr(CL);
		md(5'h02);
		rst();
		pr(NX);
		wr(8'h10, 32'h5);
		pr(NX);
		pr(NX);
		pr(NX);
		pr(EX);
		md(5'h02);
		rd(8'h10, 32'h5, 32'hFFFFFFFF);
		rst();
		pr(NX);
		repeat (IDLE - 10) @(posedge pclk);
		pr(UP);
		repeat (IDLE - 10) @(posedge pclk);
		md(5'h04);
		repeat (IDLE) @(posedge pclk);
		md(5'h02);
		rst();
		repeat (15) @(posedge pclk);
		pr(NX);
		md(5'h02);
		repeat (2) @(posedge pclk);
		results();
	end
endmodule // test_config_menu_mode_controller
